// >>> cqlg_pkg.sv
// Constants and types shared by the chopped quadrature oscillator generator
package cqlg_pkg;
  localparam int CNT_W = 5;
  localparam logic [4:0] DIV_LO_LONG = 5'h0C;
  localparam logic [4:0] DIV_LO_SHORT = 5'h03;
  localparam logic [4:0] DIV_HI_LONG = 5'h10;
  localparam logic [4:0] DIV_HI_SHORT = 5'h04;
  localparam logic [4:0] CNT_RESET = 5'h00;
  localparam int SYNC_W = 7;
  localparam int PIN_CHAIN = 0;
  localparam int PIN_FAST = 1;
  localparam int PIN_REF = 2;
  localparam int PIN_DREF = 3;
  localparam int PIN_FLAG = 4;
  localparam int PIN_CAL_EN = 5;
  localparam int PIN_CAL_VAL = 6;

  typedef struct packed {
    logic p;
    logic n;
  } cqlg_pair_s;

  localparam cqlg_pair_s PAIR_RESET = '{p: 1'b0, n: 1'b1};
endpackage

// >>> cqlg_sync2.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module cqlg_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// >>> cqlg_top.sv
// Chop divider, retiming and quadrature oscillator drive generator
`timescale 1ns/1ns
module cqlg_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic chain_clock,
  input wire logic fast_chain_clock,
  input wire logic ref_clock,
  input wire logic double_ref_clock,
  input wire logic octave_half_flag,
  input wire logic calibration_override_enable,
  input wire logic calibration_octave_half,
  input wire logic short_time_constant_select,
  output logic chop,
  output logic sample_sync,
  output logic octave_half_select,
  output cqlg_pkg::cqlg_pair_s inphase_lo_drive,
  output cqlg_pkg::cqlg_pair_s quadrature_lo_drive
);
  logic [cqlg_pkg::SYNC_W-1:0] pins_raw;
  logic [cqlg_pkg::SYNC_W-1:0] pins;
  logic [3:0] clk_prev;
  logic [1:0] sel_prev;
  logic [cqlg_pkg::CNT_W-1:0] cnt;
  logic sync_edge;
  logic chop_rt;
  logic tc_short;
  logic [1:0] sync_edges;

  function automatic logic [4:0] half_count(input logic oh, input logic short_tc);
    if (oh) begin
      half_count = short_tc ? cqlg_pkg::DIV_HI_SHORT : cqlg_pkg::DIV_HI_LONG;
    end else begin
      half_count = short_tc ? cqlg_pkg::DIV_LO_SHORT : cqlg_pkg::DIV_LO_LONG;
    end
  endfunction

  assign pins_raw = {calibration_octave_half, calibration_override_enable, octave_half_flag,
                     double_ref_clock, ref_clock, fast_chain_clock, chain_clock};

  cqlg_sync2 #(.WIDTH(cqlg_pkg::SYNC_W)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d(pins_raw),
    .q(pins)
  );

  // Select decode and edge detection on synchronised pins
  wire sel_oh = pins[cqlg_pkg::PIN_CAL_EN] ? pins[cqlg_pkg::PIN_CAL_VAL] : pins[cqlg_pkg::PIN_FLAG];
  wire [4:0] half = half_count(sel_oh, tc_short);
  wire restart = {sel_oh, tc_short} != sel_prev;
  wire chain_edge = pins[cqlg_pkg::PIN_CHAIN] != clk_prev[0];
  wire fast_rise = pins[cqlg_pkg::PIN_FAST] & ~clk_prev[1];
  wire dref_rise = pins[cqlg_pkg::PIN_DREF] & ~clk_prev[3];
  wire dref_fall = ~pins[cqlg_pkg::PIN_DREF] & clk_prev[3];
  wire half_done = chain_edge && (cnt == half - 5'h01);
  wire chopped_ref = chop_rt ^ pins[cqlg_pkg::PIN_REF];

  assign octave_half_select = sel_oh;

  always_ff @(posedge mclk) begin
    if (rst) begin
      clk_prev <= 4'h0;
      sel_prev <= 2'h0;
      tc_short <= 1'b0;
    end else begin
      clk_prev <= {pins[cqlg_pkg::PIN_DREF], pins[cqlg_pkg::PIN_REF],
                   pins[cqlg_pkg::PIN_FAST], pins[cqlg_pkg::PIN_CHAIN]};
      sel_prev <= {sel_oh, tc_short};
      tc_short <= short_time_constant_select;
    end
  end

  // Both chain edges counted so odd divisors still give equal halves
  always_ff @(posedge mclk) begin
    if (rst || restart) begin
      cnt <= cqlg_pkg::CNT_RESET;
      chop <= 1'b0;
      sample_sync <= 1'b0;
      sync_edge <= 1'b0;
    end else if (chain_edge) begin
      cnt <= half_done ? cqlg_pkg::CNT_RESET : cnt + 5'h01;
      if (half_done) begin
        chop <= ~chop;
      end
      if (half_done && !chop) begin
        sample_sync <= 1'b1;
        sync_edge <= 1'b0;
      end else if (sample_sync) begin
        sync_edge <= 1'b1;
        if (sync_edge) begin
          sample_sync <= 1'b0;
        end
      end
    end
  end

  // Retime chop and form the quadrature drives
  always_ff @(posedge mclk) begin
    if (rst) begin
      chop_rt <= 1'b0;
      inphase_lo_drive <= cqlg_pkg::PAIR_RESET;
      quadrature_lo_drive <= cqlg_pkg::PAIR_RESET;
    end else begin
      if (fast_rise) begin
        chop_rt <= chop;
      end
      if (dref_rise) begin
        inphase_lo_drive <= '{p: chopped_ref, n: ~chopped_ref};
      end
      if (dref_fall) begin
        quadrature_lo_drive <= '{p: ~chopped_ref, n: chopped_ref};
      end
    end
  end

  // Chain edges counted while sync is high
  always_ff @(posedge mclk) begin
    if (rst || !sample_sync) begin
      sync_edges <= 2'h0;
    end else if (chain_edge && sync_edges != 2'h3) begin
      sync_edges <= sync_edges + 2'h1;
    end
  end

  sequence s_sync_start;
    chain_edge && half_done && !chop && !restart;
  endsequence

  sequence s_sync_hold;
    sample_sync && !restart;
  endsequence

  sequence s_sync_fresh;
    sample_sync && !restart && sync_edges == 2'h0;
  endsequence

  sequence s_sync_second_edge;
    sample_sync && chain_edge && sync_edges == 2'h1 && !restart;
  endsequence

  property p_div_toggle(logic oh_val, logic [4:0] lim);
    @(posedge mclk) disable iff (rst)
      (chain_edge && !restart && sel_oh == oh_val && cnt == lim - 5'h01) |=> (chop != $past(chop));
  endproperty

  AST_DIV_LOW: assert property (p_div_toggle(1'b0, tc_short ? cqlg_pkg::DIV_LO_SHORT : cqlg_pkg::DIV_LO_LONG))
    else $error("chop did not toggle at low-half divisor");
  AST_DIV_HIGH: assert property (p_div_toggle(1'b1, tc_short ? cqlg_pkg::DIV_HI_SHORT : cqlg_pkg::DIV_HI_LONG))
    else $error("chop did not toggle at high-half divisor");
  AST_SYMMETRY: assert property (@(posedge mclk) disable iff (rst)
    $changed(chop) && !$past(restart) |-> $past(cnt) == $past(half) - 5'h01)
    else $error("chop half period length wrong");
  AST_SYNC_RISE: assert property (@(posedge mclk) disable iff (rst)
    s_sync_start |=> sample_sync && chop)
    else $error("sync not raised with chop rise");
  AST_SYNC_LEN: assert property (@(posedge mclk) disable iff (rst)
    s_sync_hold ##0 (chain_edge && sync_edge) |=> !sample_sync)
    else $error("sync held beyond one sample period");
  AST_RETIME: assert property (@(posedge mclk) disable iff (rst)
    $changed(chop_rt) |-> $past(fast_rise) && chop_rt == $past(chop))
    else $error("chop retimed off fast clock edge");
  AST_XOR: assert property (@(posedge mclk) disable iff (rst)
    dref_rise |=> inphase_lo_drive.p == ($past(pins[cqlg_pkg::PIN_REF]) ^ $past(chop_rt)))
    else $error("in-phase drive not chopped reference");
  AST_IPHASE: assert property (@(posedge mclk) disable iff (rst)
    $changed(inphase_lo_drive.p) |-> $past(dref_rise))
    else $error("in-phase drive changed off rising edge");
  AST_QPHASE: assert property (@(posedge mclk) disable iff (rst)
    dref_fall |=> quadrature_lo_drive.p == !$past(chopped_ref))
    else $error("quadrature drive not complement data");
  AST_PAIR: assert property (@(posedge mclk) disable iff (rst)
    inphase_lo_drive.n != inphase_lo_drive.p && quadrature_lo_drive.n != quadrature_lo_drive.p)
    else $error("drive pair not complementary");
  AST_RESTART: assert property (@(posedge mclk) disable iff (rst)
    restart |=> cnt == 5'h00 && !chop && !sample_sync)
    else $error("select change did not restart divider");
  AST_OVERRIDE: assert property (@(posedge mclk) disable iff (rst)
    pins[cqlg_pkg::PIN_CAL_EN] |-> octave_half_select == pins[cqlg_pkg::PIN_CAL_VAL])
    else $error("calibration override ignored");
  AST_QUAD_EDGE: assert property (@(posedge mclk) disable iff (rst)
    $changed(quadrature_lo_drive.p) |-> $past(dref_fall))
    else $error("quadrature drive changed off falling edge");
  AST_SYNC_IDLE: assert property (@(posedge mclk) disable iff (rst)
    !chop |-> !sample_sync)
    else $error("sync high while chop low");
  AST_SYNC_SHORT: assert property (@(posedge mclk) disable iff (rst)
    sample_sync |-> sync_edges < 2'h2)
    else $error("sync spans more than one chain period");
  AST_SYNC_KEEP: assert property (@(posedge mclk) disable iff (rst)
    s_sync_fresh |=> sample_sync)
    else $error("sync dropped before first chain edge");
  AST_SYNC_END: assert property (@(posedge mclk) disable iff (rst)
    s_sync_second_edge |=> !sample_sync && chop)
    else $error("sync not ended at second chain edge");
  AST_CNT_RANGE: assert property (@(posedge mclk) disable iff (rst)
    !restart |-> cnt < half)
    else $error("divider count beyond divisor");
  AST_CHOP_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !half_done && !restart |=> $stable(chop))
    else $error("chop moved between half periods");
  AST_CHOP_EDGE: assert property (@(posedge mclk) disable iff (rst)
    $changed(chop) && !$past(restart) |-> $past(chain_edge))
    else $error("chop moved without a chain edge");
  AST_RETIME_HOLD: assert property (@(posedge mclk) disable iff (rst)
    !fast_rise |=> $stable(chop_rt))
    else $error("retimed chop moved without fast edge");
  AST_OH_FLAG: assert property (@(posedge mclk) disable iff (rst)
    !pins[cqlg_pkg::PIN_CAL_EN] |-> octave_half_select == pins[cqlg_pkg::PIN_FLAG])
    else $error("octave half select does not follow flag");
  AST_RESET_STATE: assert property (@(posedge mclk)
    rst |=> !chop && !sample_sync && cnt == cqlg_pkg::CNT_RESET
      && inphase_lo_drive == cqlg_pkg::PAIR_RESET && quadrature_lo_drive == cqlg_pkg::PAIR_RESET)
    else $error("reset state not reached");
endmodule

// >>> cqlg_divchain.sv
// Divider-chain model that drives the clock pins
`timescale 1ns/1ns
module cqlg_divchain (
  input wire logic mclk,
  output logic chain_clock,
  output logic fast_chain_clock,
  output logic ref_clock,
  output logic double_ref_clock
);
  logic [5:0] c = 6'h00;
  logic [5:0] c2;
  assign c2 = c + 6'h02;
  always @(posedge mclk) c <= #2 c + 6'h01;
  assign chain_clock = c[5];
  assign fast_chain_clock = c[1];
  assign double_ref_clock = c[3];
  // Offset so no reference toggle meets a double-rate edge
  assign ref_clock = c2[4];
endmodule

// >>> cqlg_top_bench.sv
// Self-checking bench for the chopped oscillator generator
`timescale 1ns/1ns
module cqlg_top_bench;
  logic mclk = 1'b0, rst = 1'b1, flag = 1'b0, cal_en = 1'b0, cal_v = 1'b0, short_sel = 1'b0;
  logic chain, fast, refc, dref, chop, sync, hsel, pd, pc, ei, eq;
  cqlg_pkg::cqlg_pair_s ip, qd;
  int miscompares = 0, samples_checked = 0, h, l, s, st = 0;
  logic [4:0] cfg [6] = '{5'h00, 5'h02, 5'h11, 5'h13, 5'h1A, 5'h0D};
  int nd [6] = '{12, 3, 16, 4, 3, 16};
  always #20 mclk = ~mclk;
  cqlg_divchain u_cqlg_divchain (.mclk(mclk), .chain_clock(chain), .fast_chain_clock(fast),
    .ref_clock(refc), .double_ref_clock(dref));
  cqlg_top u_cqlg_top (.mclk(mclk), .rst(rst), .chain_clock(chain), .fast_chain_clock(fast),
    .ref_clock(refc), .double_ref_clock(dref), .octave_half_flag(flag),
    .calibration_override_enable(cal_en), .calibration_octave_half(cal_v),
    .short_time_constant_select(short_sel), .chop(chop), .sample_sync(sync),
    .octave_half_select(hsel), .inphase_lo_drive(ip), .quadrature_lo_drive(qd));
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", n, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic step();
    @(posedge mclk);
    #2;
  endtask
  task automatic meas();
    int t;
    t = 0;
    while (chop !== 1'b0 && t < 3000) begin t++; step(); end
    while (chop !== 1'b1 && t < 6000) begin t++; step(); end
    chk("sync_at_rise", sync, 1);
    h = 0; l = 0; s = 0;
    while (chop === 1'b1 && h < 3000) begin h++; s += (sync === 1'b1); step(); end
    while (chop === 1'b0 && l < 3000) begin l++; step(); end
  endtask
  task automatic rst_chk();
    chk("chop", chop, 0);
    chk("sync", sync, 0);
    chk("ip", ip, cqlg_pkg::PAIR_RESET);
    chk("qd", qd, cqlg_pkg::PAIR_RESET);
  endtask
  // Drive pairs every cycle out of reset, and the XOR and edge relation once chop has settled
  always @(posedge mclk) begin
    pd <= dref;
    pc <= chop;
    st <= (rst || chop !== pc) ? 0 : st + 1;
    if (!rst) chk("ip_n", ip.n, !ip.p);
    if (!rst) chk("qd_n", qd.n, !qd.p);
    if (dref && !pd) begin
      if (st > 40) chk("ip_p", ip.p, ei);
      ei <= refc ^ chop;
    end
    if (!dref && pd) begin
      if (st > 40) chk("qd_p", qd.p, eq);
      eq <= ~(refc ^ chop);
    end
  end
  initial begin
    #(40 * 60000);
    miscompares++;
    test_done();
  end
  initial begin
    repeat (6) step();
    rst_chk();
    rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      {flag, cal_en, cal_v, short_sel} = cfg[i][4:1];
      repeat (5) step();
      chk("half_sel", hsel, cfg[i][0]);
      meas();
      chk("high", h, nd[i] * 32);
      chk("low", l, nd[i] * 32);
      chk("sync_len", s, 64);
    end
    short_sel = ~short_sel;
    repeat (5) step();
    chk("restart_chop", chop, 0);
    chk("restart_sync", sync, 0);
    repeat (300) step();
    rst = 1'b1;
    repeat (6) step();
    rst_chk();
    test_done();
  end
endmodule
